// *** design/adcal_top.sv ***
// Converter control: pipelined DMA capture engine and calibration registers.
// Assumes converter and memory handshakes run on I_REF_CLK.
`timescale 1ns/1ps
module adcal_top import adcal_pkg::*; (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  input wire logic [13:0] I_FACTORY_OFFSET,
  input wire logic [13:0] I_FACTORY_GAIN,
  output logic O_CONV_START,
  output logic [3:0] O_CONV_CHAN,
  output logic O_CAL_REQ,
  output logic O_CAL_GAIN,
  output logic O_EXT_REF,
  output logic [13:0] O_OFFSET_COEF,
  output logic [13:0] O_GAIN_COEF,
  input wire logic I_CONV_DONE,
  input wire logic [11:0] I_CONV_RESULT,
  input wire logic [13:0] I_CAL_COEF,
  output adcal_mem_req_type O_MEM,
  input wire logic I_MEM_ACK,
  input wire logic [7:0] I_MEM_RDATA,
  input wire logic I_EXTENDED_DATA_RAM_INT_EN,
  output logic O_PORT_GATE,
  output logic O_EXTENDED_DATA_RAM_CPU_OK,
  output logic O_EXTENDED_DATA_RAM_INT_ONLY,
  output logic O_DMA_IRQ
);

  adcal_state_type state_ff;
  logic [7:0] cfg_ff;
  logic [7:0] chan_ctl_ff;
  logic cal_start_ff;
  logic cal_gain_ff;
  logic cal_kick_ff;
  logic dma_en_ff;
  logic dma_int_ff;
  logic dma_ie_ff;
  logic done_ff;
  logic boot_done_ff;
  logic [23:0] base_ff;
  logic [23:0] rd_ptr_ff;
  logic [23:0] wr_ptr_ff;
  logic [3:0] conv_chan_ff;
  logic conv_valid_ff;
  logic [3:0] fetch_id_ff;
  logic fetch_valid_ff;
  logic ending_ff;
  logic conv_seen_ff;
  logic [11:0] conv_res_ff;
  adcal_result_type res_ff;
  logic res_valid_ff;
  adcal_result_type last_res_ff;
  logic [1:0] cyc_cnt_ff;
  logic dma_run;
  logic conv_issue;
  logic cycle_end;
  logic [11:0] conv_data;
  logic dma_finish;
  logic cal_finish;
  logic boot_load;
  logic wr_cfg;
  logic wr_chan;
  logic wr_ctl3;
  logic wr_dma;
  logic wr_stat;

  // Register port write decode.
  assign wr_cfg = I_SFR_WR && (I_SFR_ADDR == ADR_CFG);
  assign wr_chan = I_SFR_WR && (I_SFR_ADDR == ADR_CHAN);
  assign wr_ctl3 = I_SFR_WR && (I_SFR_ADDR == ADR_CTL3);
  assign wr_dma = I_SFR_WR && (I_SFR_ADDR == ADR_DMA_CTL);
  assign wr_stat = I_SFR_WR && (I_SFR_ADDR == ADR_DMA_STAT);

  // Pipeline helpers; cycle zero converts a dummy, later cycles convert only a fetched channel.
  assign dma_run = (state_ff != ST_IDLE);
  assign conv_issue = conv_valid_ff || (cyc_cnt_ff == 2'h0);
  assign cycle_end = (state_ff == ST_WAIT) && (conv_seen_ff || I_CONV_DONE);
  // A result that lands on the closing edge is not in the latch yet.
  assign conv_data = I_CONV_DONE ? I_CONV_RESULT : conv_res_ff;
  assign dma_finish = cycle_end && !conv_valid_ff && !fetch_valid_ff;
  assign cal_finish = cal_start_ff && !cal_kick_ff && I_CONV_DONE && !dma_run;
  assign boot_load = !boot_done_ff;

  // Power-up flag: the first clock after reset release loads the factory set.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      boot_done_ff <= 1'b0;
    end else begin
      boot_done_ff <= 1'b1;
    end
  end

  // Plain configuration registers.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cfg_ff <= REG_RST;
      chan_ctl_ff <= REG_RST;
      base_ff <= ADDR_RST;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= I_SFR_WDATA;
      end
      if (wr_chan) begin
        chan_ctl_ff <= I_SFR_WDATA;
      end
      // Full 24-bit base gives a 16 MB capture space.
      if (I_SFR_WR && (I_SFR_ADDR == ADR_BASE0)) begin
        base_ff[7:0] <= I_SFR_WDATA;
      end
      if (I_SFR_WR && (I_SFR_ADDR == ADR_BASE1)) begin
        base_ff[15:8] <= I_SFR_WDATA;
      end
      if (I_SFR_WR && (I_SFR_ADDR == ADR_BASE2)) begin
        base_ff[23:16] <= I_SFR_WDATA;
      end
    end
  end

  // Calibration start; ignored while DMA owns the converter.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cal_start_ff <= 1'b0;
      cal_gain_ff <= 1'b0;
      cal_kick_ff <= 1'b0;
    end else begin
      cal_kick_ff <= 1'b0;
      if (wr_ctl3 && I_SFR_WDATA[CTL3_START_BIT] && !cal_start_ff
          && !dma_run && !dma_en_ff) begin
        cal_start_ff <= 1'b1;
        cal_gain_ff <= I_SFR_WDATA[CTL3_GAIN_BIT];
        cal_kick_ff <= 1'b1;
      end else if (cal_finish) begin
        cal_start_ff <= 1'b0;
      end
    end
  end

  // DMA control and done flag; the hardware set wins over a software clear.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      dma_en_ff <= 1'b0;
      dma_int_ff <= 1'b0;
      dma_ie_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      if (wr_dma) begin
        dma_en_ff <= I_SFR_WDATA[DMA_EN_BIT];
        dma_int_ff <= I_SFR_WDATA[DMA_INT_BIT];
        dma_ie_ff <= I_SFR_WDATA[DMA_IE_BIT];
      end else if (dma_finish) begin
        dma_en_ff <= 1'b0;
      end
      if (dma_finish) begin
        done_ff <= 1'b1;
      end else if (wr_stat && I_SFR_WDATA[STAT_DONE_BIT]) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Conversion result latch; the DMA pipeline picks it up at cycle end.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      conv_res_ff <= 12'h000;
    end else if (I_CONV_DONE && dma_run) begin
      conv_res_ff <= I_CONV_RESULT;
    end
  end

  // DMA sequencer: one pass ST_CYC..ST_WAIT is one DMA cycle.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_ff <= ST_IDLE;
      rd_ptr_ff <= ADDR_RST;
      wr_ptr_ff <= ADDR_RST;
      conv_chan_ff <= 4'h0;
      conv_valid_ff <= 1'b0;
      fetch_id_ff <= 4'h0;
      fetch_valid_ff <= 1'b0;
      ending_ff <= 1'b0;
      conv_seen_ff <= 1'b0;
      res_ff <= '0;
      res_valid_ff <= 1'b0;
      cyc_cnt_ff <= 2'h0;
      O_MEM <= '0;
    end else begin
      if (I_CONV_DONE && dma_run) begin
        conv_seen_ff <= 1'b1;
      end
      case (state_ff)
        ST_IDLE: begin
          if (dma_en_ff && !cal_start_ff) begin
            rd_ptr_ff <= base_ff;
            wr_ptr_ff <= base_ff;
            conv_valid_ff <= 1'b0;
            fetch_valid_ff <= 1'b0;
            res_valid_ff <= 1'b0;
            ending_ff <= 1'b0;
            cyc_cnt_ff <= 2'h0;
            state_ff <= ST_CYC;
          end
        end
        ST_CYC: begin
          conv_seen_ff <= !conv_issue;
          if (res_valid_ff) begin
            O_MEM.addr <= wr_ptr_ff;
            O_MEM.wdata <= {res_ff.chan, res_ff.data[11:8]};
            O_MEM.wr <= 1'b1;
            state_ff <= ST_WR_HI;
          end else if (!ending_ff) begin
            O_MEM.addr <= rd_ptr_ff;
            O_MEM.rd <= 1'b1;
            state_ff <= ST_RD;
          end else begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WR_HI: begin
          if (I_MEM_ACK) begin
            O_MEM.addr <= wr_ptr_ff + LO_BYTE_OFS;
            O_MEM.wdata <= res_ff.data[7:0];
            state_ff <= ST_WR_LO;
          end
        end
        ST_WR_LO: begin
          if (I_MEM_ACK) begin
            wr_ptr_ff <= wr_ptr_ff + ENTRY_BYTES;
            O_MEM.wr <= 1'b0;
            if (!ending_ff) begin
              O_MEM.addr <= rd_ptr_ff;
              O_MEM.rd <= 1'b1;
              state_ff <= ST_RD;
            end else begin
              state_ff <= ST_WAIT;
            end
          end
        end
        ST_RD: begin
          if (I_MEM_ACK) begin
            O_MEM.rd <= 1'b0;
            fetch_id_ff <= I_MEM_RDATA[CHAN_W-1:0];
            fetch_valid_ff <= (I_MEM_RDATA != ID_END_MARK);
            rd_ptr_ff <= rd_ptr_ff + ENTRY_BYTES;
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cycle_end) begin
            // Advance the three-stage pipeline: fetch, convert, store.
            res_ff <= '{chan: conv_chan_ff, data: conv_data};
            res_valid_ff <= conv_valid_ff;
            conv_chan_ff <= fetch_id_ff;
            conv_valid_ff <= fetch_valid_ff;
            fetch_valid_ff <= 1'b0;
            ending_ff <= ending_ff || !fetch_valid_ff;
            if (cyc_cnt_ff != FIRST_WR_CYCLE) begin
              cyc_cnt_ff <= cyc_cnt_ff + CYC_ONE;
            end
            state_ff <= dma_finish ? ST_IDLE : ST_CYC;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Converter drive; calibration reuses the channel select, where 1011
  // routes internal ground and 1100 the internal reference.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CONV_START <= 1'b0;
      O_CONV_CHAN <= 4'h0;
      O_CAL_REQ <= 1'b0;
      O_CAL_GAIN <= 1'b0;
      O_EXT_REF <= 1'b0;
    end else begin
      O_CONV_START <= ((state_ff == ST_CYC) && conv_issue) || cal_kick_ff;
      if (dma_run && conv_valid_ff) begin
        O_CONV_CHAN <= conv_chan_ff;
      end else begin
        O_CONV_CHAN <= chan_ctl_ff[CHAN_W-1:0];
      end
      O_CAL_REQ <= cal_start_ff && !cal_finish;
      O_CAL_GAIN <= cal_gain_ff;
      O_EXT_REF <= cfg_ff[CFG_EXTREF_BIT];
    end
  end

  // Core port arbitration while DMA runs.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_PORT_GATE <= 1'b0;
      O_EXTENDED_DATA_RAM_CPU_OK <= 1'b1;
      O_EXTENDED_DATA_RAM_INT_ONLY <= 1'b0;
    end else begin
      O_PORT_GATE <= dma_run && !dma_int_ff;
      O_EXTENDED_DATA_RAM_CPU_OK <= !dma_run || (I_EXTENDED_DATA_RAM_INT_EN && !dma_int_ff);
      O_EXTENDED_DATA_RAM_INT_ONLY <= dma_run && I_EXTENDED_DATA_RAM_INT_EN && !dma_int_ff;
    end
  end

  // Interrupt is a level that follows the done flag while enabled.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_DMA_IRQ <= 1'b0;
    end else begin
      O_DMA_IRQ <= (done_ff || dma_finish) && dma_ie_ff;
    end
  end

  // Last stored result, kept for software inspection.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      last_res_ff <= '0;
    end else if (cycle_end && conv_valid_ff) begin
      last_res_ff <= '{chan: conv_chan_ff, data: conv_data};
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SFR_RDATA <= REG_RST;
    end else if (I_SFR_RD) begin
      if (I_SFR_ADDR == ADR_CFG) begin
        O_SFR_RDATA <= cfg_ff;
      end else if (I_SFR_ADDR == ADR_CHAN) begin
        O_SFR_RDATA <= chan_ctl_ff;
      end else if (I_SFR_ADDR == ADR_CTL3) begin
        O_SFR_RDATA <= {6'h00, cal_gain_ff, cal_start_ff};
      end else if (I_SFR_ADDR == ADR_OFS_LO) begin
        O_SFR_RDATA <= O_OFFSET_COEF[COEF_LO_W-1:0];
      end else if (I_SFR_ADDR == ADR_OFS_HI) begin
        O_SFR_RDATA <= {2'h0, O_OFFSET_COEF[COEF_W-1:COEF_LO_W]};
      end else if (I_SFR_ADDR == ADR_GAIN_LO) begin
        O_SFR_RDATA <= O_GAIN_COEF[COEF_LO_W-1:0];
      end else if (I_SFR_ADDR == ADR_GAIN_HI) begin
        O_SFR_RDATA <= {2'h0, O_GAIN_COEF[COEF_W-1:COEF_LO_W]};
      end else if (I_SFR_ADDR == ADR_DMA_CTL) begin
        O_SFR_RDATA <= {5'h00, dma_ie_ff, dma_int_ff, dma_en_ff};
      end else if (I_SFR_ADDR == ADR_DMA_STAT) begin
        O_SFR_RDATA <= {5'h00, cal_start_ff, done_ff, dma_run};
      end else if (I_SFR_ADDR == ADR_BASE0) begin
        O_SFR_RDATA <= base_ff[7:0];
      end else if (I_SFR_ADDR == ADR_BASE1) begin
        O_SFR_RDATA <= base_ff[15:8];
      end else if (I_SFR_ADDR == ADR_BASE2) begin
        O_SFR_RDATA <= base_ff[23:16];
      end else if (I_SFR_ADDR == ADR_RES_LO) begin
        O_SFR_RDATA <= last_res_ff.data[7:0];
      end else if (I_SFR_ADDR == ADR_RES_HI) begin
        O_SFR_RDATA <= {last_res_ff.chan, last_res_ff.data[11:8]};
      end else begin
        O_SFR_RDATA <= REG_RST;
      end
    end
  end

  // Coefficients feed the converter directly: a larger offset word pulls
  // the transfer function down, a larger gain word steepens it.
  adcal_coef_reg u_offset (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_load_factory(boot_load),
    .i_factory(I_FACTORY_OFFSET),
    .i_cal_load(cal_finish && !cal_gain_ff),
    .i_cal_val(I_CAL_COEF),
    .i_wr_hi(I_SFR_WR && (I_SFR_ADDR == ADR_OFS_HI)),
    .i_wr_lo(I_SFR_WR && (I_SFR_ADDR == ADR_OFS_LO)),
    .i_wdata(I_SFR_WDATA),
    .o_coef(O_OFFSET_COEF)
  );

  adcal_coef_reg u_gain (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_load_factory(boot_load),
    .i_factory(I_FACTORY_GAIN),
    .i_cal_load(cal_finish && cal_gain_ff),
    .i_cal_val(I_CAL_COEF),
    .i_wr_hi(I_SFR_WR && (I_SFR_ADDR == ADR_GAIN_HI)),
    .i_wr_lo(I_SFR_WR && (I_SFR_ADDR == ADR_GAIN_LO)),
    .i_wdata(I_SFR_WDATA),
    .o_coef(O_GAIN_COEF)
  );

  // Checks on the logic above.
  AST_FIRST_WR_THIRD: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    (state_ff == ST_WR_HI) |-> (cyc_cnt_ff == FIRST_WR_CYCLE))
    else $error("Result written before the third DMA cycle.");
  AST_HI_BYTE_TAG: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    $rose(O_MEM.wr) |-> (O_MEM.wdata[7:4] == res_ff.chan))
    else $error("High result byte lacks channel code.");
  AST_FETCH_ADDR: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    $rose(O_MEM.rd) |-> (O_MEM.addr == rd_ptr_ff))
    else $error("Identifier fetched from wrong address.");
  AST_CONV_FETCHED: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    ((state_ff == ST_CYC) && conv_valid_ff) |=>
      (O_CONV_START && (O_CONV_CHAN == $past(conv_chan_ff))))
    else $error("Converted channel is not the fetched one.");
  AST_PORT_GATED: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    (dma_run && !dma_int_ff) |=> O_PORT_GATE)
    else $error("External ports not gated during DMA.");
  AST_PORT_FREE: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    (dma_run && dma_int_ff) |=> (!O_PORT_GATE && !O_EXTENDED_DATA_RAM_INT_ONLY))
    else $error("Ports blocked during internal DMA.");
  AST_EXTENDED_DATA_RAM_INT: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    (dma_run && !I_EXTENDED_DATA_RAM_INT_EN) |=> !O_EXTENDED_DATA_RAM_CPU_OK)
    else $error("Core reached extended RAM without internal RAM.");
  AST_DONE_IRQ: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    (dma_finish && dma_ie_ff) |=> (O_DMA_IRQ && done_ff && !dma_en_ff))
    else $error("Completion did not raise the interrupt.");
  AST_CAL_CLEAR: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    (cal_finish && !cal_gain_ff) |=>
      (!cal_start_ff && (O_OFFSET_COEF == $past(I_CAL_COEF))))
    else $error("Calibration result not stored.");
  AST_FACTORY_LOAD: assert property (
    @(posedge I_REF_CLK) disable iff (I_RESET)
    boot_load |=> ((O_GAIN_COEF == $past(I_FACTORY_GAIN)) && boot_done_ff))
    else $error("Factory coefficient not loaded.");

endmodule

// *** design/adcal_pkg.sv ***
// Shared constants and types for the converter DMA and calibration block.
// Assumes one clock domain and an 8-bit register port of the host core.
package adcal_pkg;

  // Register port addresses.
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_CHAN = 8'h01;
  localparam logic [7:0] ADR_CTL3 = 8'h02;
  localparam logic [7:0] ADR_OFS_LO = 8'h03;
  localparam logic [7:0] ADR_OFS_HI = 8'h04;
  localparam logic [7:0] ADR_GAIN_LO = 8'h05;
  localparam logic [7:0] ADR_GAIN_HI = 8'h06;
  localparam logic [7:0] ADR_DMA_CTL = 8'h07;
  localparam logic [7:0] ADR_DMA_STAT = 8'h08;
  localparam logic [7:0] ADR_BASE0 = 8'h09;
  localparam logic [7:0] ADR_BASE1 = 8'h0a;
  localparam logic [7:0] ADR_BASE2 = 8'h0b;
  localparam logic [7:0] ADR_RES_LO = 8'h0c;
  localparam logic [7:0] ADR_RES_HI = 8'h0d;

  // Bit positions inside the control and status registers.
  localparam int CFG_EXTREF_BIT = 6;
  localparam int CTL3_START_BIT = 0;
  localparam int CTL3_GAIN_BIT = 1;
  localparam int DMA_EN_BIT = 0;
  localparam int DMA_INT_BIT = 1;
  localparam int DMA_IE_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CAL_BIT = 2;

  // Widths.
  localparam int COEF_W = 14;
  localparam int COEF_HI_W = 6;
  localparam int COEF_LO_W = 8;
  localparam int RES_W = 12;
  localparam int CHAN_W = 4;
  localparam int ADDR_W = 24;

  // Channel codes and list markers.
  localparam logic [3:0] CH_ANALOG_GROUND_INPUT = 4'hb;
  localparam logic [3:0] CH_VREF = 4'hc;
  localparam logic [7:0] ID_END_MARK = 8'hff;

  // Reset values and pipeline figures.
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [13:0] COEF_RST = 14'h0000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [23:0] ENTRY_BYTES = 24'h000002;
  localparam logic [23:0] LO_BYTE_OFS = 24'h000001;
  localparam logic [1:0] FIRST_WR_CYCLE = 2'h2;
  localparam logic [1:0] CYC_ONE = 2'h1;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcal_mem_req_type;

  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] data;
  } adcal_result_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CYC,
    ST_WR_HI,
    ST_WR_LO,
    ST_RD,
    ST_WAIT
  } adcal_state_type;

endpackage

// *** design/adcal_coef_reg.sv ***
// One 14-bit calibration coefficient split into upper and lower bytes.
// Assumes load strobes are single-cycle pulses from the same clock.
`timescale 1ns/1ps
module adcal_coef_reg import adcal_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load_factory,
  input wire logic [13:0] i_factory,
  input wire logic i_cal_load,
  input wire logic [13:0] i_cal_val,
  input wire logic i_wr_hi,
  input wire logic i_wr_lo,
  input wire logic [7:0] i_wdata,
  output logic [13:0] o_coef
);

  // Factory load beats calibration, which beats software, since the
  // power-up image must never be half overwritten by a stray write.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_coef <= COEF_RST;
    end else if (i_load_factory) begin
      o_coef <= i_factory;
    end else if (i_cal_load) begin
      o_coef <= i_cal_val;
    end else begin
      if (i_wr_hi) begin
        o_coef[COEF_W-1:COEF_LO_W] <= i_wdata[COEF_HI_W-1:0];
      end
      if (i_wr_lo) begin
        o_coef[COEF_LO_W-1:0] <= i_wdata;
      end
    end
  end

endmodule

// *** tb/adcal_mem_model.sv ***
// Partner model: byte-wide data memory on the DMA port.
// Assumes requests hold steady until acknowledged.
`timescale 1ns/1ps
module adcal_mem_model import adcal_pkg::*; (
  input wire logic i_clk,
  input wire adcal_mem_req_type i_mem,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] cnt = 2'h0;
  logic slow = 1'b0;
  // Quick and slow answers alternate to stall the pipeline.
  // Read data is inverted when idle so a stale byte never looks fresh.
  always @(negedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if ((i_mem.rd || i_mem.wr) && o_ack !== 1'b1) begin
      if (cnt == {slow, 1'b1}) begin
        cnt <= 2'h0;
        slow <= ~slow;
        o_ack <= 1'b1;
        if (i_mem.wr) mem[i_mem.addr[7:0]] <= i_mem.wdata;
        else o_rdata <= mem[i_mem.addr[7:0]];
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule

// *** tb/adc_dma_and_calibration_test.sv ***
// Self-checking bench for the converter DMA and calibration block.
// Assumes the memory partner model and a converter stub driven here.
`timescale 1ns/1ps
module adc_dma_and_calibration_test import adcal_pkg::*;;
  logic clk = 0, rst = 1, wr = 0, rd = 0, done = 0, ack, gate, ok, io, irq;
  logic [7:0] adr = 0, wd = 0, rdat, v, lo, hi, id [0:2];
  logic [13:0] fo, fg, cal_v = 0, ccoef = 0, oc, gc;
  logic [11:0] res = 0;
  logic [3:0] chan;
  logic [2:0] cc = 0;
  logic start, creq, cgain, eref, xen = 1;
  adcal_mem_req_type mreq;
  int n_errors = 0, checks_done = 0, cyc = 0, i, seed = 32'hdff111ec;
  adcal_top dut_u (.I_REF_CLK(clk), .I_RESET(rst), .I_SFR_ADDR(adr),
    .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wd), .O_SFR_RDATA(rdat),
    .I_FACTORY_OFFSET(fo), .I_FACTORY_GAIN(fg), .O_CONV_START(start),
    .O_CONV_CHAN(chan), .O_CAL_REQ(creq), .O_CAL_GAIN(cgain),
    .O_EXT_REF(eref), .O_OFFSET_COEF(oc), .O_GAIN_COEF(gc),
    .I_CONV_DONE(done), .I_CONV_RESULT(res), .I_CAL_COEF(ccoef),
    .O_MEM(mreq), .I_MEM_ACK(ack), .I_MEM_RDATA(v), .I_EXTENDED_DATA_RAM_INT_EN(xen),
    .O_PORT_GATE(gate), .O_EXTENDED_DATA_RAM_CPU_OK(ok), .O_EXTENDED_DATA_RAM_INT_ONLY(io),
    .O_DMA_IRQ(irq));
  adcal_mem_model mem_u (.i_clk(clk), .i_mem(mreq), .o_ack(ack),
    .o_rdata(v));
  // Clock at 40 MHz; a cycle ceiling cuts a hang short.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end
  // Expected conversion code for a channel, so results show their source.
  function automatic logic [11:0] res_of(input logic [3:0] c);
    return {c, ~c, c + 4'h1};
  endfunction
  // Converter stub: answers three cycles after each start pulse.
  always @(negedge clk) begin
    done <= 1'b0;
    res <= ~res;
    if (start) cc <= 3'h3;
    else if (cc != 3'h0) cc <= cc - 3'h1;
    if (cc == 3'h1) begin
      done <= 1'b1;
      res <= res_of(chan);
      ccoef <= cal_v;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input bit w);
    adr = a;
    wd = d;
    wr = w;
    rd = ~w;
    @(negedge clk);
    wr = 0;
    rd = 0;
    @(negedge clk);
  endtask
  // Starts one calibration and checks the routed channel and new value.
  task automatic cal(input logic [3:0] code, input logic g);
    cal_v = 14'($random(seed));
    sfr(ADR_CHAN, {4'h0, code}, 1);
    sfr(ADR_CTL3, {6'h0, g, 1'b1}, 1);
    for (i = 0; i < 20 && !start; i++) @(negedge clk);
    check(chan, code);
    check({creq, cgain}, {1'b1, g});
    for (i = 0; i < 20 && creq; i++) @(negedge clk);
    check(g ? gc : oc, cal_v);
    sfr(ADR_CTL3, 8'h00, 0);
    check(rdat[0], 1'b0);
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence: reset, registers, calibration, then two DMA captures.
  initial begin
    fo = 14'($random(seed));
    fg = 14'($random(seed));
    repeat (16) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    check({oc, gc}, {fo, fg});
    for (int a = 3; a < 7; a++) begin
      if (a[0]) lo = 8'($random(seed));
      else hi = 8'($random(seed));
      sfr(8'(a), a[0] ? lo : hi, 1);
      sfr(8'(a), 8'h00, 0);
      check(rdat, a[0] ? lo : {2'h0, hi[5:0]});
      if (!a[0]) check(a == 4 ? oc : gc, {hi[5:0], lo});
    end
    sfr(8'h20, 8'h00, 0);
    check(rdat, 8'h00);
    cal(CH_ANALOG_GROUND_INPUT, 0);
    cal(CH_VREF, 1);
    sfr(ADR_CFG, 8'h40, 1);
    check(eref, 1'b1);
    cal(4'h2, 0);
    cal(4'h5, 1);
    // Capture twice: to outside memory with internal RAM on, then to
    // internal RAM with it off, so both port-sharing cases are seen.
    for (int p = 0; p < 2; p++) begin
      xen = (p == 0);
      for (int k = 0; k < 3; k++) begin
        id[k] = 8'($random(seed)) & 8'h07;
        mem_u.mem[8'h10 + 2 * k] = id[k];
      end
      mem_u.mem[8'h16] = ID_END_MARK;
      sfr(ADR_BASE0, 8'h10, 1);
      sfr(ADR_BASE1, 8'h00, 1);
      sfr(ADR_BASE2, 8'h00, 1);
      sfr(ADR_DMA_CTL, (p == 0) ? 8'h05 : 8'h07, 1);
      repeat (4) @(negedge clk);
      check({gate, ok, io}, (p == 0) ? 3'b111 : 3'b000);
      for (i = 0; i < 400 && !irq; i++) @(negedge clk);
      check(irq, 1'b1);
      for (int k = 0; k < 3; k++) begin
        check(mem_u.mem[8'h10 + 2 * k],
          {id[k][3:0], 4'(res_of(id[k][3:0]) >> 8)});
        check(mem_u.mem[8'h11 + 2 * k],
          res_of(id[k][3:0]) & 12'h0ff);
      end
      sfr(ADR_DMA_STAT, 8'h00, 0);
      check(rdat[STAT_DONE_BIT], 1'b1);
      sfr(ADR_DMA_CTL, 8'h00, 0);
      check(rdat[DMA_EN_BIT], 1'b0);
      sfr(ADR_DMA_STAT, 8'h02, 1);
      @(negedge clk);
      check({irq, gate}, 2'b00);
    end
    test_done();
  end
endmodule
